// ===== core/blob_policy_pkg.sv
// Purpose: shared constants and types for the blob type policy and kdf select block
// Assumes: 40 MHz clk_i, synchronous active-high reset
// Notes: register offsets are byte addresses on the plain register port
package blob_policy_pkg;

	// register offsets (byte addresses, one word each)
	localparam logic [7:0] ctrl_offset = 8'h00;
	localparam logic [7:0] status_offset = 8'h04;
	localparam logic [7:0] modifier0_offset = 8'h08;
	localparam logic [7:0] modifier1_offset = 8'h0c;
	localparam logic [7:0] modifier2_offset = 8'h10;
	localparam logic [7:0] modifier3_offset = 8'h14;
	localparam logic [7:0] partition_offset = 8'h18;
	localparam logic [7:0] type_id_offset = 8'h1c;

	// control field positions
	localparam int ctrl_start_pos = 0;
	localparam int ctrl_decap_pos = 1;
	localparam int ctrl_format_pos = 2;
	localparam int ctrl_content_pos = 4;
	localparam int ctrl_state_pos = 7;
	localparam int ctrl_memory_pos = 9;
	localparam int ctrl_to_keyreg_pos = 10;

	// blob layout byte offsets
	localparam logic [7:0] wrapped_key_bytes = 8'h20;
	localparam logic [7:0] data_offset_bytes = 8'h20;
	localparam logic [7:0] tag_bytes = 8'h10;

	// key widths
	localparam int blob_key_bits = 256;
	localparam int general_modifier_bits = 128;
	localparam int secure_modifier_bits = 64;

	// type identifier constants fed to the kdf
	localparam logic [3:0] general_memory_const = 4'h5;
	localparam logic [3:0] secure_memory_const = 4'ha;
	localparam logic [3:0] verify_derivation_const = 4'hc;

	// error codes
	localparam logic [3:0] err_none = 4'h0;
	localparam logic [3:0] err_test_state = 4'h1;
	localparam logic [3:0] err_partition = 4'h2;
	localparam logic [3:0] err_destination = 4'h3;
	localparam logic [3:0] err_tag = 4'h4;
	localparam logic [3:0] err_bad_type = 4'h5;

	// reset values
	localparam logic [31:0] ctrl_reset = 32'h0000_0000;

	// blob formats
	typedef enum logic [1:0] {
		format_normal = 2'b00,
		format_test = 2'b01,
		format_verify = 2'b10
	} format_type;

	// blob contents
	typedef enum logic [2:0] {
		content_general = 3'b000,
		content_job_ecb = 3'b001,
		content_job_ccm = 3'b010,
		content_trusted_ecb = 3'b011,
		content_trusted_ccm = 3'b100
	} content_type;

	// security states
	typedef enum logic [1:0] {
		state_trusted = 2'b00,
		state_secure = 2'b01,
		state_nonsecure = 2'b10
	} security_type;

	// sequencer states
	typedef enum logic [2:0] {
		seq_idle = 3'b000,
		seq_derive = 3'b001,
		seq_unwrap = 3'b010,
		seq_run = 3'b011,
		seq_check = 3'b100,
		seq_done = 3'b101
	} seq_type;

endpackage

// ===== core/blob_policy.sv
// Purpose: blob type selection, policy checks and kdf input select
// Assumes: aes engine, kdf, rng and memory mover sit outside on the same clock
// Notes: engines answer with one-cycle done pulses; partition hits come from the mover
`timescale 1ns/1ps
`default_nettype none

module blob_policy
	import blob_policy_pkg::*;
#(
	parameter int partition_width = 4
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [31:0] reg_rdata_o,
	// partition registers of the addressed partition
	input wire logic [7:0] partition_domain_owner_i,
	input wire logic [15:0] partition_access_perms_i,
	input wire logic [31:0] partition_access_groups_i,
	// memory mover reports
	input wire logic mover_access_i,
	input wire logic mover_in_secure_i,
	input wire logic [partition_width-1:0] mover_partition_i,
	// engines
	input wire logic kdf_done_i,
	input wire logic unwrap_done_i,
	input wire logic ccm_done_i,
	input wire logic tag_ok_i,
	// kdf request
	output logic kdf_start_o,
	output logic kdf_use_master_o,
	output logic [15:0] kdf_type_id_o,
	output logic [127:0] kdf_modifier_o,
	output logic [55:0] kdf_partition_o,
	// engine control
	output logic rng_key_req_o,
	output logic unwrap_start_o,
	output logic unwrap_ccm_o,
	output logic unwrap_trusted_o,
	output logic ccm_start_o,
	output logic ccm_decrypt_o,
	output logic emit_clear_keys_o,
	output logic emit_wrap_key_only_o,
	output logic [7:0] data_offset_o,
	output logic [7:0] tag_length_o,
	// result
	output logic load_keyreg_o,
	output logic abort_o,
	output logic busy_o
);

	// whole block state
	typedef struct packed {
		logic [31:0] rdata;
		logic [10:0] ctrl;
		logic [127:0] modifier;
		seq_type seq;
		logic [3:0] err;
		logic done;
		logic part_valid;
		logic [partition_width-1:0] part;
		logic [55:0] part_regs;
		logic kdf_go;
		logic unwrap_go;
		logic ccm_go;
		logic load_key;
		logic abort;
	} state_type;

	state_type cur;
	state_type nxt;

	// decoded fields of the control word
	format_type fmt;
	content_type cont;
	security_type sec;
	logic secure_mem;
	logic decap;
	logic key_content;
	logic type_valid;

	// category fields, each picked independently
	always_comb
	begin
		fmt = format_type'(cur.ctrl[ctrl_format_pos +: 2]);
		cont = content_type'(cur.ctrl[ctrl_content_pos +: 3]);
		sec = security_type'(cur.ctrl[ctrl_state_pos +: 2]);
		secure_mem = cur.ctrl[ctrl_memory_pos];
		decap = cur.ctrl[ctrl_decap_pos];
		key_content = (cont != content_general);
		type_valid = (fmt != 2'b11) && (cur.ctrl[ctrl_content_pos +: 3] <= 3'b100)
			&& (sec != 2'b11);
	end

	// next state
	always_comb
	begin
		nxt = cur;
		nxt.kdf_go = 1'b0;
		nxt.unwrap_go = 1'b0;
		nxt.ccm_go = 1'b0;
		nxt.load_key = 1'b0;
		nxt.abort = 1'b0;
		// read data one cycle after the strobe
		nxt.rdata = 32'h0000_0000;
		if (reg_read_i)
		begin
			case (reg_addr_i)
				ctrl_offset: nxt.rdata = {21'h0, cur.ctrl};
				status_offset: nxt.rdata = {24'h0, cur.err, cur.done, cur.seq};
				modifier0_offset: nxt.rdata = cur.modifier[31:0];
				modifier1_offset: nxt.rdata = cur.modifier[63:32];
				modifier2_offset: nxt.rdata = cur.modifier[95:64];
				modifier3_offset: nxt.rdata = cur.modifier[127:96];
				partition_offset: nxt.rdata = {{(32-partition_width){1'b0}}, cur.part};
				type_id_offset: nxt.rdata = {16'h0, kdf_type_id_o};
				default: nxt.rdata = 32'h0000_0000;
			endcase
		end
		// writes while idle only; start launches a job
		if (reg_write_i && cur.seq == seq_idle)
		begin
			case (reg_addr_i)
				ctrl_offset:
				begin
					nxt.ctrl = reg_wdata_i[10:0];
					nxt.ctrl[ctrl_start_pos] = 1'b0;
					if (reg_wdata_i[ctrl_start_pos])
					begin
						nxt.seq = seq_derive;
						nxt.kdf_go = 1'b1;
						nxt.err = err_none;
						nxt.done = 1'b0;
						nxt.part_valid = 1'b0;
						nxt.part_regs = {partition_domain_owner_i,
							partition_access_perms_i, partition_access_groups_i};
					end
				end
				modifier0_offset: nxt.modifier[31:0] = reg_wdata_i;
				modifier1_offset: nxt.modifier[63:32] = reg_wdata_i;
				modifier2_offset: nxt.modifier[95:64] = reg_wdata_i;
				modifier3_offset: nxt.modifier[127:96] = reg_wdata_i;
				default: nxt.ctrl = cur.ctrl;
			endcase
		end
		// sequencer
		case (cur.seq)
			seq_idle: nxt.seq = nxt.seq;
			seq_derive:
			begin
				// test format refused outside non-secure state
				if (!type_valid)
				begin
					nxt.err = err_bad_type;
					nxt.seq = seq_done;
				end
				else if (fmt == format_test && sec != state_nonsecure)
				begin
					nxt.err = err_test_state;
					nxt.seq = seq_done;
				end
				else if (kdf_done_i)
				begin
					// verify format stops after the derived key
					if (fmt == format_verify)
						nxt.seq = seq_done;
					else if (key_content && !decap)
					begin
						nxt.seq = seq_unwrap;
						nxt.unwrap_go = 1'b1;
					end
					else
					begin
						nxt.seq = seq_run;
						nxt.ccm_go = 1'b1;
					end
				end
			end
			seq_unwrap:
			begin
				// session key recovered inside, then ccm under blob key
				if (unwrap_done_i)
				begin
					nxt.seq = seq_run;
					nxt.ccm_go = 1'b1;
				end
			end
			seq_run:
			begin
				// secure blob decap must land in secure memory
				if (mover_access_i && secure_mem && decap && !mover_in_secure_i)
				begin
					nxt.err = err_destination;
					nxt.seq = seq_done;
				end
				// second partition ends the job before access
				else if (mover_access_i && secure_mem && cur.part_valid
					&& mover_partition_i != cur.part)
				begin
					nxt.err = err_partition;
					nxt.seq = seq_done;
				end
				else
				begin
					// general blobs accept any memory
					if (mover_access_i && secure_mem && !cur.part_valid)
					begin
						nxt.part_valid = 1'b1;
						nxt.part = mover_partition_i;
					end
					if (ccm_done_i)
						nxt.seq = seq_check;
				end
			end
			seq_check:
			begin
				// wrong type gives wrong key, caught by tag
				nxt.seq = seq_done;
				if (decap && !tag_ok_i)
					nxt.err = err_tag;
				else if (decap && key_content && cur.ctrl[ctrl_to_keyreg_pos])
					nxt.load_key = 1'b1;
			end
			seq_done:
			begin
				nxt.done = 1'b1;
				nxt.abort = (cur.err != err_none);
				nxt.seq = seq_idle;
			end
			default: nxt.seq = seq_idle;
		endcase
	end

	// state register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cur <= '0;
			cur.ctrl <= ctrl_reset[10:0];
			cur.seq <= seq_idle;
		end
		else
			cur <= nxt;
	end

	// kdf selection: type code, key source, modifier, partition binding
	always_comb
	begin
		// type id: memory const, verify-format const, content, state, direction-free
		kdf_type_id_o = {secure_mem ? secure_memory_const : general_memory_const,
			(fmt == format_verify) ? verify_derivation_const : 4'h0,
			1'b0, cont, 2'b00, sec};
		// master key except in non-secure state or for test format
		// test blobs always wrap under the known test key
		kdf_use_master_o = (sec != state_nonsecure) && (fmt != format_test);
		if (secure_mem)
		begin
			kdf_modifier_o = {64'h0, cur.modifier[secure_modifier_bits-1:0]};
			kdf_partition_o = cur.part_regs;
		end
		else
		begin
			kdf_modifier_o = cur.modifier[general_modifier_bits-1:0];
			kdf_partition_o = 56'h0;
		end
	end

	// engine strobes and layout outputs
	assign kdf_start_o = cur.kdf_go;
	assign rng_key_req_o = cur.ccm_go && !decap;
	assign unwrap_start_o = cur.unwrap_go;
	assign unwrap_ccm_o = (cont == content_job_ccm) || (cont == content_trusted_ccm);
	assign unwrap_trusted_o = (cont == content_trusted_ecb) || (cont == content_trusted_ccm);
	assign ccm_start_o = cur.ccm_go;
	assign ccm_decrypt_o = decap;
	assign emit_clear_keys_o = (fmt == format_test);
	assign emit_wrap_key_only_o = (fmt == format_verify);
	assign data_offset_o = data_offset_bytes;
	assign tag_length_o = tag_bytes;
	assign load_keyreg_o = cur.load_key;
	assign abort_o = cur.abort;
	assign busy_o = (cur.seq != seq_idle);
	assign reg_rdata_o = cur.rdata;

	// test format never runs outside non-secure state
	test_state_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(cur.seq == seq_derive && type_valid && fmt == format_test && sec != state_nonsecure)
		|=> (cur.err == err_test_state) ##1 abort_o)
		else $error("test blob allowed in wrong state");

	// second partition aborts
	partition_split_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(cur.seq == seq_run && mover_access_i && secure_mem && mover_in_secure_i
		&& cur.part_valid && mover_partition_i != cur.part) |-> ##2 abort_o)
		else $error("partition change not aborted");

	// secure decap outside secure memory aborts
	secure_dest_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(cur.seq == seq_run && mover_access_i && secure_mem && decap && !mover_in_secure_i)
		|=> cur.err == err_destination)
		else $error("secure blob decap escaped");

	// key never loaded after bad tag
	key_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(cur.seq == seq_check && !tag_ok_i) |=> !load_keyreg_o)
		else $error("key released after tag failure");

	// key source follows state
	key_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
		kdf_start_o |-> (kdf_use_master_o == (sec != state_nonsecure && fmt != format_test)))
		else $error("wrong kdf key source");

	// key register loaded only after a passing decap check
	key_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
		load_keyreg_o |-> $past(cur.seq) == seq_check && $past(tag_ok_i) && decap)
		else $error("key loaded without passing check");

	// every refused job ends with exactly one abort pulse
	sequence err_latched_s;
		cur.seq == seq_done && cur.err != err_none;
	endsequence
	abort_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		err_latched_s |=> abort_o ##1 !abort_o)
		else $error("error without single abort pulse");

	// key encap unwraps before ccm
	unwrap_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ccm_start_o && key_content && !decap) |-> $past(cur.seq) == seq_unwrap)
		else $error("key blob ccm without unwrap");

	// verify format skips the data engines
	verify_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(cur.seq == seq_derive && fmt == format_verify && kdf_done_i && type_valid)
		|=> cur.seq == seq_done ##1 !ccm_start_o)
		else $error("verify blob ran data engine");

	// secure kdf uses the secure memory constant and a 64-bit modifier
	secure_kdf_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(kdf_start_o && secure_mem) |-> kdf_type_id_o[15:12] == secure_memory_const
		&& kdf_modifier_o[127:64] == 64'h0)
		else $error("secure kdf input wrong");

	// general kdf constant
	general_kdf_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(kdf_start_o && !secure_mem) |-> kdf_type_id_o[15:12] == general_memory_const)
		else $error("general kdf constant wrong");

endmodule

`default_nettype wire

// ===== tb/engine_model.sv
// Purpose: far-side model of kdf, aes engines and memory mover
// Assumes: one clock; answers come after a delay set by the bench
// Notes: mover secure and partition lines are inverted after each access cycle ends
`timescale 1ns/1ps
`default_nettype none
module engine_model
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// behaviour chosen by the bench
	input wire logic [3:0] lat_i,
	input wire logic tag_good_i,
	input wire logic secure_i,
	input wire logic [3:0] part_a_i,
	input wire logic [3:0] part_b_i,
	// requests from the block
	input wire logic kdf_start_i,
	input wire logic unwrap_start_i,
	input wire logic ccm_start_i,
	// answers to the block
	output logic [2:0] done_o,
	output logic tag_ok_o,
	output logic access_o,
	output logic in_secure_o,
	output logic [3:0] partition_o
);
	// tag verdict is a level chosen by the bench
	assign tag_ok_o = tag_good_i;
	// one-cycle done pulse after the set delay
	task automatic answer(input int k);
		repeat (lat_i) @(posedge clk_i);
		done_o[k] <= 1'b1;
		@(posedge clk_i);
		done_o[k] <= 1'b0;
	endtask
	// one mover access, lines inverted once it ends
	task automatic access(input logic [3:0] p);
		@(posedge clk_i);
		access_o <= 1'b1;
		in_secure_o <= secure_i;
		partition_o <= p;
		@(posedge clk_i);
		access_o <= 1'b0;
		in_secure_o <= ~secure_i;
		partition_o <= ~p;
	endtask
	// serve one request at a time
	initial
	begin
		done_o = 3'h0;
		access_o = 1'b0;
		in_secure_o = 1'b0;
		partition_o = 4'h0;
		forever
		begin
			@(posedge clk_i);
			if (rst_i !== 1'b1 && kdf_start_i === 1'b1)
				answer(0);
			else if (rst_i !== 1'b1 && unwrap_start_i === 1'b1)
				answer(1);
			else if (rst_i !== 1'b1 && ccm_start_i === 1'b1)
			begin
				access(part_a_i);
				access(part_b_i);
				answer(2);
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/test_blob_policy.sv
// Purpose: self-checking bench for the blob type policy block
// Assumes: 40 MHz clock, engine model on the far side
// Notes: each scenario task judges its results before returning; t_formats and later ones start jobs
`timescale 1ns/1ps
`default_nettype none
`define check_eq(a, b) \
	begin \
		checks_done++; \
		if ((a) !== (b)) \
		begin \
			n_fail++; \
			$display("BAD %0t got %h want %h", $time, (a), (b)); \
		end \
	end
module test_blob_policy
	import blob_policy_pkg::*;
;
	logic clk_i, rst_i, reg_write_i, reg_read_i, mover_access_i, mover_in_secure_i;
	logic kdf_done_i, unwrap_done_i, ccm_done_i, tag_ok_i, kdf_start_o, kdf_use_master_o;
	logic rng_key_req_o, unwrap_start_o, unwrap_ccm_o, unwrap_trusted_o, ccm_start_o;
	logic ccm_decrypt_o, emit_clear_keys_o, emit_wrap_key_only_o, load_keyreg_o, abort_o, busy_o;
	logic [7:0] reg_addr_i, partition_domain_owner_i, data_offset_o, tag_length_o;
	logic [31:0] reg_wdata_i, reg_rdata_o, partition_access_groups_i;
	logic [15:0] partition_access_perms_i, kdf_type_id_o;
	logic [3:0] mover_partition_i, lat, part_a, part_b;
	logic [127:0] kdf_modifier_o;
	logic [55:0] kdf_partition_o;
	logic tag_good, secure;
	int n_fail, checks_done;
	// block under test
	blob_policy #(.partition_width(4)) DUT
	(
		.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
		.partition_domain_owner_i, .partition_access_perms_i, .partition_access_groups_i,
		.mover_access_i, .mover_in_secure_i, .mover_partition_i, .kdf_done_i, .unwrap_done_i,
		.ccm_done_i, .tag_ok_i, .kdf_start_o, .kdf_use_master_o, .kdf_type_id_o,
		.kdf_modifier_o, .kdf_partition_o, .rng_key_req_o, .unwrap_start_o, .unwrap_ccm_o,
		.unwrap_trusted_o, .ccm_start_o, .ccm_decrypt_o, .emit_clear_keys_o,
		.emit_wrap_key_only_o, .data_offset_o, .tag_length_o, .load_keyreg_o, .abort_o, .busy_o
	);
	// far-side engines and mover
	engine_model far
	(
		.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .tag_good_i(tag_good), .secure_i(secure),
		.part_a_i(part_a), .part_b_i(part_b), .kdf_start_i(kdf_start_o),
		.unwrap_start_i(unwrap_start_o), .ccm_start_i(ccm_start_o),
		.done_o({ccm_done_i, unwrap_done_i, kdf_done_i}), .tag_ok_o(tag_ok_i),
		.access_o(mover_access_i), .in_secure_o(mover_in_secure_i), .partition_o(mover_partition_i)
	);
	// 25 ns clock
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// verdict and end of run
	task automatic summarize();
		$display("TB: %0d checks, %0d mismatches", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge clk_i);
		reg_write_i <= 1'b0;
	endtask
	// one-cycle read, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge clk_i);
		reg_read_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask
	// control word with the start bit set
	function automatic logic [31:0] mk(input logic dc, input logic [1:0] f, input logic [2:0] c,
		input logic [1:0] s, input logic m, input logic k);
		return {21'h0, k, m, s, c, f, dc, 1'b1};
	endfunction
	// start a job, collect pulses until idle, then check status
	task automatic run(input logic [31:0] c, input logic [3:0] e, output logic [4:0] seen);
		int i;
		logic [31:0] st;
		seen = 5'h0;
		wr(ctrl_offset, c);
		#1;
		if (e === err_none)
			`check_eq(kdf_start_o, 1'b1)
		for (i = 0; i < 400 && busy_o !== 1'b0; i++)
		begin
			seen = seen | {abort_o, load_keyreg_o, unwrap_start_o, ccm_start_o, rng_key_req_o};
			@(posedge clk_i);
			#1;
		end
		seen = seen | {abort_o, load_keyreg_o, unwrap_start_o, ccm_start_o, rng_key_req_o};
		if (i == 400)
		begin
			n_fail++;
			$display("BAD %0t job never finished", $time);
			summarize();
		end
		rd(status_offset, st);
		`check_eq(st[7:3], {e, 1'b1})
	endtask
	// values straight after reset
	task automatic t_reset();
		logic [31:0] d;
		rd(ctrl_offset, d);
		`check_eq(d, ctrl_reset)
		rd(8'h40, d);
		`check_eq(d, 32'h0)
		`check_eq(kdf_type_id_o, {general_memory_const, 12'h000})
		rd(type_id_offset, d);
		`check_eq(d, {16'h0, general_memory_const, 12'h000})
		`check_eq(data_offset_o, data_offset_bytes)
		`check_eq(tag_length_o, tag_bytes)
	endtask
	// every type combination gives its expected identifier and key source; normal and test formats share one identifier
	task automatic t_types();
		logic [15:0] w;
		for (int m = 0; m < 2; m++)
			for (int f = 0; f < 3; f++)
				for (int c = 0; c < 5; c++)
					for (int s = 0; s < 3; s++)
					begin
						wr(ctrl_offset, mk(1'b0, 2'(f), 3'(c), 2'(s), 1'(m), 1'b0) & 32'hffff_fffe);
						#1;
						w = {(m == 1) ? secure_memory_const : general_memory_const,
							(f == 2) ? verify_derivation_const : 4'h0, 1'b0, 3'(c), 2'b00, 2'(s)};
						`check_eq(kdf_type_id_o, w)
						`check_eq(kdf_use_master_o, (s != 2 && f != 1))
					end
	endtask
	// modifier words land in order in the kdf input
	task automatic t_modifier();
		wr(ctrl_offset, 32'h0000_0000);
		wr(modifier0_offset, 32'h0123_4567);
		wr(modifier1_offset, 32'h89ab_cdef);
		wr(modifier2_offset, 32'h0f1e_2d3c);
		wr(modifier3_offset, 32'h4b5a_6978);
		#1;
		`check_eq(kdf_modifier_o, 128'h4b5a6978_0f1e2d3c_89abcdef_01234567)
		wr(ctrl_offset, 32'h0000_0200);
		#1;
		`check_eq(kdf_modifier_o, {64'h0, 64'h89abcdef_01234567})
	endtask
	// plain, test and verify format encapsulations
	task automatic t_formats();
		logic [4:0] seen;
		run(mk(1'b0, 2'd0, 3'd0, 2'd0, 1'b0, 1'b0), err_none, seen);
		`check_eq(seen, 5'b00011)
		`check_eq({emit_clear_keys_o, emit_wrap_key_only_o, ccm_decrypt_o}, 3'b000)
		run(mk(1'b0, 2'd3, 3'd0, 2'd0, 1'b0, 1'b0), err_bad_type, seen);
		`check_eq(seen[4], 1'b1)
		run(mk(1'b0, 2'd1, 3'd0, 2'd0, 1'b0, 1'b0), err_test_state, seen);
		`check_eq(seen[4], 1'b1)
		run(mk(1'b1, 2'd1, 3'd0, 2'd1, 1'b0, 1'b0), err_test_state, seen);
		`check_eq(seen[4], 1'b1)
		run(mk(1'b0, 2'd1, 3'd0, 2'd2, 1'b0, 1'b0), err_none, seen);
		`check_eq(seen, 5'b00011)
		`check_eq(emit_clear_keys_o, 1'b1)
		run(mk(1'b0, 2'd2, 3'd0, 2'd1, 1'b0, 1'b0), err_none, seen);
		`check_eq({seen[4], emit_wrap_key_only_o}, 2'b01)
	endtask
	// key blobs unwrap first with the chosen session key and mode
	task automatic t_key_encap();
		logic [4:0] seen;
		lat = 4'd3;
		for (int c = 1; c < 5; c++)
		begin
			run(mk(1'b0, 2'd0, 3'(c), 2'd1, 1'b0, 1'b0), err_none, seen);
			`check_eq(seen, 5'b00111)
			`check_eq(unwrap_ccm_o, (c == 2 || c == 4))
			`check_eq(unwrap_trusted_o, (c >= 3))
		end
		lat = 4'd0;
	endtask
	// decapsulation: bad tag, key register load, plain data
	task automatic t_decap();
		logic [4:0] seen;
		tag_good = 1'b0;
		run(mk(1'b1, 2'd0, 3'd1, 2'd0, 1'b0, 1'b1), err_tag, seen);
		`check_eq({seen[4:3], seen[0], ccm_decrypt_o}, 4'b1001)
		tag_good = 1'b1;
		run(mk(1'b1, 2'd0, 3'd1, 2'd0, 1'b0, 1'b1), err_none, seen);
		`check_eq({seen[4:3], seen[0]}, 3'b010)
		run(mk(1'b1, 2'd0, 3'd0, 2'd0, 1'b0, 1'b0), err_none, seen);
		`check_eq({seen[4:3], seen[0]}, 3'b000)
	endtask
	// memory type policing and partition binding
	task automatic t_memory();
		logic [4:0] seen;
		logic [55:0] p1;
		logic [31:0] d;
		secure = 1'b0;
		run(mk(1'b1, 2'd0, 3'd0, 2'd1, 1'b1, 1'b0), err_destination, seen);
		`check_eq(seen[4], 1'b1)
		run(mk(1'b1, 2'd0, 3'd0, 2'd1, 1'b0, 1'b0), err_none, seen);
		`check_eq(seen[4], 1'b0)
		secure = 1'b1;
		part_b = 4'h6;
		run(mk(1'b1, 2'd0, 3'd0, 2'd1, 1'b1, 1'b0), err_partition, seen);
		`check_eq(seen[4], 1'b1)
		part_b = part_a;
		run(mk(1'b0, 2'd0, 3'd0, 2'd1, 1'b1, 1'b0), err_none, seen);
		p1 = kdf_partition_o;
		@(posedge clk_i);
		partition_domain_owner_i <= 8'h22;
		run(mk(1'b0, 2'd0, 3'd0, 2'd1, 1'b1, 1'b0), err_none, seen);
		`check_eq({seen[4], kdf_partition_o !== p1}, 2'b01)
		rd(partition_offset, d);
		`check_eq(d, {28'h0, part_a})
	endtask
	// main sequence
	initial
	begin
		n_fail = 0;
		checks_done = 0;
		rst_i = 1'b1;
		{reg_addr_i, reg_wdata_i, reg_write_i, reg_read_i} = '0;
		partition_domain_owner_i = 8'h11;
		partition_access_perms_i = 16'h00f3;
		partition_access_groups_i = 32'h0000_0101;
		{lat, tag_good, secure, part_a, part_b} = {4'd0, 1'b1, 1'b1, 4'h2, 4'h2};
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_types();
		t_modifier();
		t_formats();
		t_key_encap();
		t_decap();
		t_memory();
		summarize();
	end
endmodule
`default_nettype wire
